// ==== dv/chip_select_decoder_tb.sv ====
module chip_select_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import csel_pkg::*;
    logic clk = 0, arst_n = 0, cycle_start = 0, wr = 0, internal_access = 0;
    logic [31:0] addr = 0, rnd = 32'h2fc5bc84;
    logic [3:0] space = 0, sel_n, got, seen;
    logic global_mode, access_refused, port_16, transfer_ack, busy, p16, rf;
    base_reg_t base_cfg [NUM_SEL];
    mask_reg_t mask_cfg [NUM_SEL];
    int n_errors = 0, n_checks = 0, cyc = 0, nw = 0;
    always #10 clk = ~clk;
    chip_select_decoder u_dut (.clk, .arst_n, .base_cfg, .mask_cfg, .cycle_start, .addr,
        .space, .wr, .internal_access, .sel_n, .global_mode, .access_refused, .port_16,
        .transfer_ack, .busy);
    ext_mem u_mem (.clk, .sel_n, .ack(transfer_ack), .got);
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // wait cycles between acceptance and acknowledge, as the rules set them
    function automatic int exp_cycles(logic f, logic [1:0] d);
        return f ? 0 : int'(d) + 1;
    endfunction
    // start lasts one edge; strobes watched until acknowledge, 8 cycles at most
    task automatic acc(logic [31:0] a, logic w, logic i);
        logic done;
        done = 1'b0;
        seen = 4'hf;
        p16 = 1'b0;
        rf = 1'b0;
        nw = 0;
        @(posedge clk);
        #1 {addr, wr, internal_access, cycle_start} = {a, w, i, 1'b1};
        @(posedge clk);
        #1 cycle_start = 1'b0;
        for (int k = 0; k < 8 && !done; k++) begin
            seen &= sel_n;
            if (access_refused === 1'b1) rf = 1'b1;
            if (transfer_ack === 1'b1) begin
                p16 = port_16;
                done = 1'b1;
            end else begin
                nw++;
                @(posedge clk);
                #1;
            end
        end
        $display("access %h done", a);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        foreach (base_cfg[j]) {base_cfg[j], mask_cfg[j]} = '0;
        repeat (12) @(posedge clk);
        #1 arst_n = 1;
        chk(global_mode, 1);
        chk({busy, access_refused, sel_n}, 6'h0f);
        repeat (4) begin
            rnd = xs(rnd);
            space = rnd[7:4];
            acc(rnd, rnd[0], 0);
            chk({seen, p16}, 5'h1d);
            chk(nw, exp_cycles(1'b0, BOOT_WAIT));
        end
        acc(BOOT_SP_ADDR, 0, 0);
        chk({seen, p16}, 5'h1d);
        acc(BOOT_PC_ADDR, 1, 0);
        chk({seen, rf}, 5'h1c);
        acc(32'h00000004, 0, 1);
        chk(seen, 4'hf);
        chk(nw, 8);
        rnd = xs(rnd);
        space = 4'h0;
        base_cfg[1] = '{rnd[31:8], 4'h0, 1'b1, 1'b0, 1'b1};
        mask_cfg[1] = '{24'h0000ff, 4'h0, PORT_16, rnd[1:0]};
        base_cfg[2] = '{24'h400000, 4'h0, 1'b0, 1'b1, 1'b1};
        mask_cfg[2] = '{24'h00ffff, 4'h0, PORT_16, 2'h3};
        base_cfg[3] = '{24'h500000, 4'h0, 1'b0, 1'b0, 1'b0};
        mask_cfg[3] = '{24'h0, 4'hf, PORT_16, 2'h0};
        mask_cfg[0] = '{24'h0, 4'h0, PORT_8, 2'h1};
        base_cfg[0] = '{24'h0, 4'h0, 1'b0, 1'b0, 1'b1};
        @(posedge clk);
        #1 chk(global_mode, 0);
        acc({rnd[31:16], 16'h1234}, 0, 0);
        chk({seen, p16}, 5'h1b);
        chk(nw, exp_cycles(1'b0, rnd[1:0]));
        @(posedge clk);
        #1 chk(got, 4'h2);
        acc({rnd[31:16], 16'h12fe}, 1, 0);
        chk({seen, rf}, 5'h1f);
        acc({~rnd[31:24], 24'h801000}, 0, 0);
        chk(seen, 4'hf);
        space = 4'h5;
        acc({rnd[31:16], 16'h0000}, 0, 0);
        chk(seen, 4'hf);
        space = 4'h0;
        acc(BOOT_PC_ADDR, 0, 0);
        chk({seen, p16}, 5'h1c);
        chk(nw, exp_cycles(1'b0, 2'h1));
        acc(32'h40123456, 0, 0);
        chk({seen, p16}, 5'h17);
        chk(nw, exp_cycles(1'b1, 2'h3));
        acc(32'h50000010, 0, 0);
        chk(seen, 4'hf);
        base_cfg[0].entry_valid = 0;
        repeat (2) @(posedge clk);
        #1 chk(global_mode, 0);
        base_cfg[0] = '0;
        arst_n = 0;
        @(posedge clk);
        #1 chk({global_mode, busy}, 2'h2);
        arst_n = 1;
        rnd = xs(rnd);
        acc({rnd[31:12], 12'h800}, 0, 0);
        chk({seen, p16}, 5'h1d);
        chk(nw, exp_cycles(1'b0, BOOT_WAIT));
        wrap_up();
    end
endmodule

// ==== dv/ext_mem.sv ====
module ext_mem (
    input wire logic clk,
    input wire logic [3:0] sel_n,
    input wire logic ack,
    output logic [3:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    // 16-bit device leaning on the internal acknowledge
    always @(posedge clk) begin
        if (ack) got <= ~sel_n;
    end
endmodule

// ==== hdl/chip_select_decoder.sv ====
// Functional notes
// - four chip selects, each with its own base and mask register pair
// - a select's settings act only while its entry_valid bit is set
// - block starts at base; mask sets power-of-two size, 256 bytes to 4G
// - 8-bit port on data lines 15-8; 16-bit port odd, even, word
// - port width per select comes from port_width_sel in mask register
// - write_protect_bit set refuses writes inside that select's range
// - fast_term_en acknowledges early for a two-cycle external access
// - internal acknowledge after zero to three wait states per ack_delay_sel
// - address bits 31-8 decoded plus optional space-code check under mask
// - after reset boot_select asserts for all addresses except internal ones
// - in global mode boot_select is 16-bit, three wait states, any space
// - boot memory supplies stack pointer at 0 and program counter at 4
// - global mode lasts until select 0 entry_valid is set
// - global mode returns only through system reset
module chip_select_decoder (
    input wire logic clk,
    input wire logic arst_n,
    input wire csel_pkg::base_reg_t base_cfg [csel_pkg::NUM_SEL],
    input wire csel_pkg::mask_reg_t mask_cfg [csel_pkg::NUM_SEL],
    input wire logic cycle_start,
    input wire logic [31:0] addr,
    input wire logic [csel_pkg::SPACE_W-1:0] space,
    input wire logic wr,
    input wire logic internal_access,
    output logic [csel_pkg::NUM_SEL-1:0] sel_n,
    output logic global_mode,
    output logic access_refused,
    output logic port_16,
    output logic transfer_ack,
    output logic busy
);
    import csel_pkg::*;

    typedef enum logic [1:0] {IDLE, WAIT, ACK} state_t;
    state_t state_ff, nxt_state;
    logic global_ff;
    logic [NUM_SEL-1:0] sel_ff, nxt_sel;
    logic port16_ff, nxt_port16;
    logic refused_ff, nxt_refused;
    logic [WAIT_W-1:0] wait_ff, nxt_wait;

    wire logic [NUM_SEL-1:0] hit;
    wire logic [NUM_SEL-1:0] blocked;
    wire logic [NUM_SEL-1:0] sel_hit;
    wire logic [$clog2(NUM_SEL)-1:0] win;
    wire logic any_hit;
    wire logic boot_hit;
    wire logic start_ok;
    wire logic refuse;
    wire logic go_ext;
    wire logic fast;
    wire logic wide;
    wire logic [WAIT_W-1:0] delay;
    wire logic wait_done;

    genvar g;
    generate
        for (g = 0; g < NUM_SEL; g++) begin : g_sel
            csel_cfg_if cfg ();
            assign cfg.base = base_cfg[g];
            assign cfg.mask = mask_cfg[g];
            assign hit[g] = cfg.hit;
            assign blocked[g] = cfg.wr_blocked;
            csel_match u_match (
                .addr(addr),
                .space(space),
                .wr(wr),
                .cfg(cfg)
            );
        end
    endgenerate

    // lowest select wins overlapping ranges so only one strobe drives a device
    assign win = hit[0] ? 2'd0 : hit[1] ? 2'd1 : hit[2] ? 2'd2 : 2'd3;
    assign any_hit = |hit;
    // global mode: select 0 answers every external address, any space
    assign boot_hit = global_ff && !internal_access;
    // protection is ignored while booting so the boot memory stays writable
    assign refuse = !global_ff && any_hit && blocked[win];
    // internal cycles never run on the external bus
    assign start_ok = cycle_start && (state_ff == IDLE) && !internal_access;
    assign go_ext = boot_hit || (any_hit && !refuse);
    assign sel_hit = boot_hit ? 4'h1 : (go_ext ? (4'h1 << win) : 4'h0);

    // fast termination skips the wait state count entirely
    assign fast = !boot_hit && base_cfg[win].fast_term_en;
    assign wide = boot_hit || (mask_cfg[win].port_width_sel == PORT_16);
    assign delay = boot_hit ? BOOT_WAIT : mask_cfg[win].ack_delay_sel;
    assign wait_done = (wait_ff == '0);

    always_comb begin
        nxt_state = state_ff;
        nxt_sel = sel_ff;
        nxt_port16 = port16_ff;
        nxt_refused = 1'b0;
        nxt_wait = wait_ff;
        unique case (state_ff)
            IDLE: begin
                if (start_ok && refuse) begin
                    // refused write: no strobe, no acknowledge
                    nxt_refused = 1'b1;
                end else if (start_ok && go_ext) begin
                    nxt_sel = sel_hit;
                    nxt_port16 = wide;
                    nxt_wait = fast ? FAST_WAIT : delay;
                    nxt_state = fast ? ACK : WAIT;
                end
            end
            WAIT: begin
                if (wait_done) begin
                    nxt_state = ACK;
                end else begin
                    nxt_wait = wait_ff - 2'h1;
                end
            end
            ACK: begin
                // strobe drops with the acknowledge so back-to-back cycles stay apart
                nxt_state = IDLE;
                nxt_sel = '0;
            end
            default: begin
                nxt_state = IDLE;
                nxt_sel = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= IDLE;
            sel_ff <= '0;
            port16_ff <= 1'b0;
            refused_ff <= 1'b0;
            wait_ff <= RST_WAIT;
        end else begin
            state_ff <= nxt_state;
            sel_ff <= nxt_sel;
            port16_ff <= nxt_port16;
            refused_ff <= nxt_refused;
            wait_ff <= nxt_wait;
        end
    end

    // only reset sets global mode; clearing entry_valid later does not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            global_ff <= 1'b1;
        end else if (base_cfg[0].entry_valid) begin
            global_ff <= 1'b0;
        end
    end

    assign sel_n = ~sel_ff;
    assign global_mode = global_ff;
    assign access_refused = refused_ff;
    assign port_16 = port16_ff;
    assign transfer_ack = (state_ff == ACK);
    assign busy = (state_ff != IDLE);

    sequence s_boot_start;
        start_ok && boot_hit;
    endsequence

    sequence s_fast_start;
        start_ok && go_ext && fast;
    endsequence

    sequence s_no_ack_4;
        !transfer_ack [*4];
    endsequence

    sequence s_ack_now;
        transfer_ack;
    endsequence

    a_sel_onehot: assert property (
        @(posedge clk) disable iff (!arst_n) $onehot0(sel_ff))
        else $error("more than one select strobe active");

    a_boot_wait: assert property (
        @(posedge clk) disable iff (!arst_n) s_boot_start |=> s_no_ack_4 ##1 s_ack_now)
        else $error("boot select acknowledge not after three wait states");

    a_boot_wide: assert property (
        @(posedge clk) disable iff (!arst_n) s_boot_start |=> port_16 && sel_ff[0])
        else $error("boot select not a 16-bit port on select 0");

    a_fast_ack: assert property (
        @(posedge clk) disable iff (!arst_n) s_fast_start |=> s_ack_now)
        else $error("fast termination acknowledge late");

    a_ext_delay: assert property (
        @(posedge clk) disable iff (!arst_n)
        start_ok && go_ext && !fast |=> ##[1:4] transfer_ack)
        else $error("internal acknowledge outside wait state range");

    a_refuse_quiet: assert property (
        @(posedge clk) disable iff (!arst_n)
        start_ok && refuse |=> access_refused && (sel_ff == '0) && !busy)
        else $error("protected write reached the bus");

    a_miss_quiet: assert property (
        @(posedge clk) disable iff (!arst_n)
        start_ok && !go_ext && !refuse |=> (sel_ff == '0) && !busy)
        else $error("select asserted without a match");

    a_internal_skip: assert property (
        @(posedge clk) disable iff (!arst_n)
        (state_ff == IDLE) && cycle_start && internal_access |=> (sel_ff == '0) && !busy)
        else $error("internal access ran an external cycle");

    a_global_sticky: assert property (
        @(posedge clk) disable iff (!arst_n) !global_ff |=> !global_ff)
        else $error("global mode returned without reset");
endmodule

// ==== hdl/csel_cfg_if.sv ====
interface csel_cfg_if;
    import csel_pkg::*;
    base_reg_t base;
    mask_reg_t mask;
    logic hit;
    logic wr_blocked;
    modport decoder (input base, input mask, output hit, output wr_blocked);
    modport top (output base, output mask, input hit, input wr_blocked);
endinterface

// ==== hdl/csel_match.sv ====
module csel_match (
    input wire logic [31:0] addr,
    input wire logic [csel_pkg::SPACE_W-1:0] space,
    input wire logic wr,
    csel_cfg_if.decoder cfg
);
    import csel_pkg::*;
    wire logic addr_ok;
    wire logic space_ok;
    // masked bits are don't-care, so the block is a power of two at base
    assign addr_ok = ((addr[31:8] ^ cfg.base.base) & ~cfg.mask.mask) == '0;
    assign space_ok = ((space ^ cfg.base.space_code) & ~cfg.mask.space_code_mask) == '0;
    assign cfg.hit = cfg.base.entry_valid && addr_ok && space_ok;
    assign cfg.wr_blocked = cfg.hit && wr && cfg.base.write_protect;
endmodule

// ==== hdl/csel_pkg.sv ====
package csel_pkg;
    localparam int NUM_SEL = 4;
    localparam int ADDR_W = 32;
    localparam int SPACE_W = 4;
    localparam int BLK_W = 24;              // address bits 31..8 decoded; 256-byte minimum block
    localparam int WAIT_W = 2;
    localparam logic [1:0] BOOT_WAIT = 2'h3;
    localparam logic [1:0] FAST_WAIT = 2'h0;
    localparam logic [1:0] RST_WAIT = 2'h0;
    localparam logic [31:0] BOOT_SP_ADDR = 32'h00000000;
    localparam logic [31:0] BOOT_PC_ADDR = 32'h00000004;
    typedef enum logic {PORT_8, PORT_16} port_width_t;
    typedef struct packed {
        logic [BLK_W-1:0] base;
        logic [SPACE_W-1:0] space_code;
        logic write_protect;
        logic fast_term_en;
        logic entry_valid;
    } base_reg_t;
    typedef struct packed {
        logic [BLK_W-1:0] mask;
        logic [SPACE_W-1:0] space_code_mask;
        port_width_t port_width_sel;
        logic [WAIT_W-1:0] ack_delay_sel;
    } mask_reg_t;
    localparam int BASE_REG_W = BLK_W + SPACE_W + 3;
    localparam int MASK_REG_W = BLK_W + SPACE_W + 1 + WAIT_W;
endpackage
